// ==== hdl/spm_dev.sv ====
/*
 * Device end of the scan-port programming link: TAP controller, instruction
 * register, reset, entry, command and virtual page load/read chains.
 * Assumes tck/tms/tdi arrive asynchronously and are oversampled by clk_in;
 * the flash, page buffer and reset tree sit outside on the user ports.
 */
`timescale 1ns/1ns
// Contract
// - Scan port needs fuse set, disable clear
// - Ext reset clears disable after two clocks
// - Host keeps pins dedicated for scan/debug
// - All scan registers shift LSB first
// - Instruction register is four bits wide
// - Run-Test/Idle makes internal clocks, idle point
// - Opcode C selects one-bit reset register
// - Reset bit one holds device in reset
// - Reset stretched by fuse-selected time-out
// - Host resets device before entering programming
// - Opcode 4 compares 16-bit signature at update
// - Signature 1010_0011_0111_0000 enables programming
// - Entry register clears at power-on, host clears
// - Opcode 5 captures previous result, 15 bits
// - Shift result out while command shifts in
// - Update applies command; idle visit executes
// - Opcode 6 is 2048-bit chain, 8-bit register
// - Page load writes bytes during shift only
// - Opcode 7 is 2056-bit chain, 8-bit register
// - Page read fetches bytes during shift, ignores TDI
// - Page chains only when device first in chain
module spm_dev
  import spm_pkg::*;
#(
  parameter int TOUT_BASE = TOUT_BASE_CYC
) (
  input logic clk_in,
  input logic rst_n_in,
  spm_link_if.dev link,
  input logic fuse_en_in,
  input logic disable_set_in,
  input logic ext_rst_n_in,
  input logic [1:0] tout_sel_in,
  input logic [CMD_W-1:0] result_in,
  input logic [BYTE_W-1:0] rd_data_in,
  output logic chip_rst_out,
  output logic prog_mode_out,
  output logic disable_bit_out,
  output logic [CMD_W-1:0] cmd_out,
  output logic cmd_apply_out,
  output logic cmd_exec_out,
  output logic pbuf_wr_out,
  output logic [ADDR_W-1:0] pbuf_addr_out,
  output logic [BYTE_W-1:0] pbuf_data_out,
  output logic rd_req_out,
  output logic [ADDR_W-1:0] rd_addr_out
);
  if (TOUT_BASE < 1 || TOUT_BASE > 1023) begin : g_chk
    $error("TOUT_BASE must lie in 1..1023");
  end

  typedef struct packed {
    spm_tap_t tap;
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0] xr_s;
    logic dis;
    logic [1:0] dis_cnt;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic rst_reg;
    logic [TOUT_W-1:0] tout;
    logic chip_rst;
    logic [EN_W-1:0] en_sh;
    logic prog;
    logic [CMD_W-1:0] cmd_sh;
    logic [CMD_W-1:0] cmd;
    logic cmd_upd;
    logic cmd_exec;
    logic [BYTE_W-1:0] pb_sh;
    logic [2:0] bit_cnt;
    logic [ADDR_W-1:0] idx;
    logic [BYTE_W-1:0] pb_data;
    logic [ADDR_W-1:0] pb_addr;
    logic pb_wr;
    logic rd_req;
    logic [ADDR_W-1:0] rd_addr;
    logic tdo;
  } spm_dev_st_t;

  spm_dev_st_t s_ff;
  spm_dev_st_t nxt_s;

  function automatic spm_tap_t tap_next(spm_tap_t t, logic m);
    case (t)
      T_RESET: tap_next = m ? T_RESET : T_IDLE;
      T_IDLE: tap_next = m ? T_SEL_DR : T_IDLE;
      T_SEL_DR: tap_next = m ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
      T_SH_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: tap_next = m ? T_UPD_DR : T_PA_DR;
      T_PA_DR: tap_next = m ? T_EX2_DR : T_PA_DR;
      T_EX2_DR: tap_next = m ? T_UPD_DR : T_SH_DR;
      T_UPD_DR: tap_next = m ? T_SEL_DR : T_IDLE;
      T_SEL_IR: tap_next = m ? T_RESET : T_CAP_IR;
      T_CAP_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
      T_SH_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: tap_next = m ? T_UPD_IR : T_PA_IR;
      T_PA_IR: tap_next = m ? T_EX2_IR : T_PA_IR;
      T_EX2_IR: tap_next = m ? T_UPD_IR : T_SH_IR;
      T_UPD_IR: tap_next = m ? T_SEL_DR : T_IDLE;
      default: tap_next = T_RESET;
    endcase
  endfunction

  always_comb begin
    logic rise;
    logic fall;
    logic tdi;
    logic ext_low;
    logic hold;
    logic scan_ok;
    rise = 1'b0;
    fall = 1'b0;
    tdi = 1'b0;
    ext_low = 1'b0;
    hold = 1'b0;
    scan_ok = 1'b0;
    nxt_s = s_ff;
    nxt_s.tck_s = {s_ff.tck_s[1:0], link.tck};
    nxt_s.tms_s = {s_ff.tms_s[0], link.tms};
    nxt_s.tdi_s = {s_ff.tdi_s[0], link.tdi};
    nxt_s.xr_s = {s_ff.xr_s[0], ~ext_rst_n_in};
    nxt_s.cmd_upd = 1'b0;
    nxt_s.cmd_exec = 1'b0;
    nxt_s.pb_wr = 1'b0;
    nxt_s.rd_req = 1'b0;
    rise = s_ff.tck_s[1] & ~s_ff.tck_s[2];
    fall = ~s_ff.tck_s[1] & s_ff.tck_s[2];
    tdi = s_ff.tdi_s[1];
    ext_low = s_ff.xr_s[1];

    // Pin reclaim only works through the reset pin; scan and debug users
    // must never set the disable bit in the first place.
    if (disable_set_in) begin
      nxt_s.dis = 1'b1;
      nxt_s.dis_cnt = 2'h0;
    end else if (s_ff.dis && ext_low) begin
      nxt_s.dis_cnt = s_ff.dis_cnt + 2'h1;
      if (s_ff.dis_cnt == 2'(DIS_CLR_CYC - 1)) begin
        nxt_s.dis = 1'b0;
      end
    end else begin
      nxt_s.dis_cnt = 2'h0;
    end

    hold = s_ff.rst_reg | ext_low;
    if (hold) begin
      nxt_s.tout = TOUT_W'(TOUT_BASE << (2 * tout_sel_in));
    end else if (s_ff.tout != '0) begin
      nxt_s.tout = s_ff.tout - TOUT_W'(1);
    end
    nxt_s.chip_rst = hold | (s_ff.tout != '0);

    scan_ok = fuse_en_in & ~s_ff.dis;
    if (!scan_ok) begin
      nxt_s.tap = T_RESET;
      nxt_s.ir = IR_RESET_VAL;
      nxt_s.rst_reg = 1'b0;
      nxt_s.tdo = 1'b0;
    end else if (rise) begin
      nxt_s.tap = tap_next(s_ff.tap, s_ff.tms_s[1]);
      case (s_ff.tap)
        T_RESET: begin
          nxt_s.ir = IR_RESET_VAL;
          nxt_s.rst_reg = 1'b0;
        end
        T_IDLE: begin
          if (s_ff.ir == OP_PROG_CMD && s_ff.prog) begin
            nxt_s.cmd_exec = 1'b1;
          end
        end
        T_CAP_IR: nxt_s.ir_sh = IR_CAPTURE;
        T_SH_IR: nxt_s.ir_sh = {tdi, s_ff.ir_sh[IR_W-1:1]};
        T_UPD_IR: nxt_s.ir = s_ff.ir_sh;
        T_CAP_DR: begin
          case (s_ff.ir)
            OP_PROG_CMD: nxt_s.cmd_sh = result_in;
            OP_PAGE_LOAD, OP_PAGE_READ: begin
              nxt_s.bit_cnt = 3'h0;
              nxt_s.idx = '0;
            end
            default: nxt_s.byp = 1'b0;
          endcase
        end
        T_SH_DR: begin
          case (s_ff.ir)
            OP_DEV_RESET: nxt_s.rst_reg = tdi;
            OP_PROG_ENTRY: nxt_s.en_sh = {tdi, s_ff.en_sh[EN_W-1:1]};
            OP_PROG_CMD: nxt_s.cmd_sh = {tdi, s_ff.cmd_sh[CMD_W-1:1]};
            OP_PAGE_LOAD: begin
              nxt_s.pb_sh = {tdi, s_ff.pb_sh[BYTE_W-1:1]};
              nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
              if (s_ff.bit_cnt == 3'h7) begin
                nxt_s.pb_wr = s_ff.prog;
                nxt_s.pb_data = {tdi, s_ff.pb_sh[BYTE_W-1:1]};
                nxt_s.pb_addr = s_ff.idx;
                nxt_s.idx = s_ff.idx + ADDR_W'(1);
              end
            end
            OP_PAGE_READ: begin
              // The first byte comes out one byte late, hence the 8 lead bits.
              nxt_s.pb_sh = {1'b0, s_ff.pb_sh[BYTE_W-1:1]};
              nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
              if (s_ff.bit_cnt == 3'h0) begin
                nxt_s.rd_req = s_ff.prog;
                nxt_s.rd_addr = s_ff.idx;
              end
              if (s_ff.bit_cnt == 3'h7) begin
                nxt_s.pb_sh = rd_data_in;
                nxt_s.idx = s_ff.idx + ADDR_W'(1);
              end
            end
            default: nxt_s.byp = tdi;
          endcase
        end
        T_UPD_DR: begin
          if (s_ff.ir == OP_PROG_ENTRY) begin
            nxt_s.prog = (s_ff.en_sh == PROG_SIGNATURE);
          end
          if (s_ff.ir == OP_PROG_CMD && s_ff.prog) begin
            nxt_s.cmd = s_ff.cmd_sh;
            nxt_s.cmd_upd = 1'b1;
          end
        end
        default: nxt_s.tap = tap_next(s_ff.tap, s_ff.tms_s[1]);
      endcase
    end else if (fall) begin
      if (s_ff.tap == T_SH_IR) begin
        nxt_s.tdo = s_ff.ir_sh[0];
      end else if (s_ff.tap == T_SH_DR) begin
        case (s_ff.ir)
          OP_DEV_RESET: nxt_s.tdo = s_ff.rst_reg;
          OP_PROG_ENTRY: nxt_s.tdo = s_ff.en_sh[0];
          OP_PROG_CMD: nxt_s.tdo = s_ff.cmd_sh[0];
          OP_PAGE_LOAD, OP_PAGE_READ: nxt_s.tdo = s_ff.pb_sh[0];
          default: nxt_s.tdo = s_ff.byp;
        endcase
      end
    end
  end

  // Of the resets, the entry register and mode clear only on power-on reset, not on TAP reset.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.tdo = s_ff.tdo;
  assign chip_rst_out = s_ff.chip_rst;
  assign prog_mode_out = s_ff.prog;
  assign disable_bit_out = s_ff.dis;
  assign cmd_out = s_ff.cmd;
  assign cmd_apply_out = s_ff.cmd_upd;
  assign cmd_exec_out = s_ff.cmd_exec;
  assign pbuf_wr_out = s_ff.pb_wr;
  assign pbuf_addr_out = s_ff.pb_addr;
  assign pbuf_data_out = s_ff.pb_data;
  assign rd_req_out = s_ff.rd_req;
  assign rd_addr_out = s_ff.rd_addr;
endmodule

// ==== hdl/spm_host.sv ====
/*
 * Programmer end of the scan-port link: walks the TAP from Run-Test/Idle,
 * scans IR words or DR words of up to 4095 bits, and makes tck with a divider.
 * Assumes the device is first in the chain and sends tdo from a flip-flop.
 */
`timescale 1ns/1ns
module spm_host
  import spm_pkg::*;
#(
  parameter int TCK_HALF = TCK_HALF_CYC
) (
  input logic clk_in,
  input logic rst_n_in,
  spm_link_if.host link,
  input logic cmd_valid_in,
  input spm_kind_t cmd_kind_in,
  input logic [LEN_W-1:0] cmd_len_in,
  input logic [15:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic word_take_out,
  output logic [15:0] rx_word_out,
  output logic rx_valid_out,
  output logic done_out
);
  if (TCK_HALF < 8 || TCK_HALF > 255) begin : g_chk
    $error("TCK_HALF must lie in 8..255 to cover the device sampling delay");
  end

  typedef enum logic {H_IDLE, H_RUN} spm_hst_t;

  typedef struct packed {
    spm_hst_t st;
    logic rdy;
    logic [7:0] div;
    logic tck;
    logic tms;
    logic tdi;
    logic [1:0] tdo_s;
    logic [5:0] pre_v;
    logic [2:0] pre_n;
    logic [1:0] post_n;
    logic [LEN_W-1:0] cnt;
    logic [15:0] sh;
    logic [3:0] sb;
    logic [15:0] cap;
    logic [3:0] cb;
    logic capf;
    logic take;
    logic [15:0] rxw;
    logic rxv;
    logic done;
  } spm_host_st_t;

  spm_host_st_t s_ff;
  spm_host_st_t nxt_s;

  always_comb begin
    logic pres;
    logic edge_now;
    pres = 1'b0;
    edge_now = 1'b0;
    nxt_s = s_ff;
    nxt_s.tdo_s = {s_ff.tdo_s[0], link.tdo};
    nxt_s.take = 1'b0;
    nxt_s.rxv = 1'b0;
    nxt_s.done = 1'b0;
    if (s_ff.st == H_IDLE) begin
      if (cmd_valid_in) begin
        // Reset, signature and clearing words are the caller's to order.
        nxt_s.st = H_RUN;
        nxt_s.div = 8'h00;
        nxt_s.sh = cmd_data_in;
        nxt_s.sb = 4'h0;
        nxt_s.cb = 4'h0;
        nxt_s.cap = 16'h0000;
        nxt_s.take = 1'b1;
        nxt_s.cnt = '0;
        nxt_s.post_n = 2'h0;
        case (cmd_kind_in)
          HK_RESET: begin
            nxt_s.pre_v = PRE_RESET;
            nxt_s.pre_n = PRE_RESET_N;
          end
          HK_IDLE: begin
            nxt_s.pre_v = PRE_IDLE;
            nxt_s.pre_n = PRE_IDLE_N;
          end
          HK_IR: begin
            nxt_s.pre_v = PRE_IR;
            nxt_s.pre_n = PRE_IR_N;
            nxt_s.cnt = LEN_W'(IR_W);
            nxt_s.post_n = POST_SCAN_N;
          end
          default: begin
            nxt_s.pre_v = PRE_DR;
            nxt_s.pre_n = PRE_DR_N;
            nxt_s.cnt = cmd_len_in;
            nxt_s.post_n = POST_SCAN_N;
          end
        endcase
        pres = 1'b1;
      end
    end else begin
      if (s_ff.div == 8'(TCK_HALF - 1)) begin
        nxt_s.div = 8'h00;
        nxt_s.tck = ~s_ff.tck;
        edge_now = 1'b1;
      end else begin
        nxt_s.div = s_ff.div + 8'h01;
      end
      if (edge_now && !s_ff.tck && s_ff.capf) begin
        nxt_s.cap[s_ff.cb] = s_ff.tdo_s[1];
        if (s_ff.cb == 4'hF || s_ff.tms) begin
          nxt_s.rxw = nxt_s.cap;
          nxt_s.rxv = 1'b1;
          nxt_s.cap = 16'h0000;
          nxt_s.cb = 4'h0;
        end else begin
          nxt_s.cb = s_ff.cb + 4'h1;
        end
      end
      pres = edge_now & s_ff.tck;
    end

    // Pins change at a tck fall or when a command starts, half a period before the device samples.
    if (pres) begin
      if (nxt_s.pre_n != 3'h0) begin
        nxt_s.tms = nxt_s.pre_v[0];
        nxt_s.tdi = 1'b0;
        nxt_s.pre_v = {1'b0, nxt_s.pre_v[5:1]};
        nxt_s.pre_n = nxt_s.pre_n - 3'h1;
        nxt_s.capf = 1'b0;
      end else if (nxt_s.cnt != '0) begin
        nxt_s.tms = (nxt_s.cnt == LEN_W'(1));
        nxt_s.tdi = nxt_s.sh[0];
        nxt_s.sh = {1'b0, nxt_s.sh[15:1]};
        nxt_s.sb = nxt_s.sb + 4'h1;
        if (nxt_s.sb == 4'h0 && nxt_s.cnt != LEN_W'(1)) begin
          nxt_s.sh = cmd_data_in;
          nxt_s.take = 1'b1;
        end
        nxt_s.cnt = nxt_s.cnt - LEN_W'(1);
        nxt_s.capf = 1'b1;
      end else if (nxt_s.post_n != 2'h0) begin
        nxt_s.tms = (nxt_s.post_n == POST_SCAN_N);
        nxt_s.tdi = 1'b0;
        nxt_s.post_n = nxt_s.post_n - 2'h1;
        nxt_s.capf = 1'b0;
      end else begin
        // Stop with tms low so the device rests in Run-Test/Idle.
        nxt_s.st = H_IDLE;
        nxt_s.tms = 1'b0;
        nxt_s.capf = 1'b0;
        nxt_s.done = 1'b1;
      end
    end
    nxt_s.rdy = (nxt_s.st == H_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.tck = s_ff.tck;
  assign link.tms = s_ff.tms;
  assign link.tdi = s_ff.tdi;
  assign cmd_ready_out = s_ff.rdy;
  assign word_take_out = s_ff.take;
  assign rx_word_out = s_ff.rxw;
  assign rx_valid_out = s_ff.rxv;
  assign done_out = s_ff.done;
endmodule

// ==== hdl/spm_link_if.sv ====
/*
 * The four scan pins between programmer and device, one modport per end.
 * Assumes both ends share the bench; tck is made by the host end.
 */
`timescale 1ns/1ns
interface spm_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport dev (input tck, input tms, input tdi, output tdo);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface

// ==== hdl/spm_pkg.sv ====
/*
 * Shared constants and types for the scan-port programming link: opcodes,
 * register widths, the entry signature, timing counts and the TAP states.
 * Assumes a single 125 MHz system clock on both ends of the link.
 */
package spm_pkg;
  localparam int CLK_NS = 8;
  localparam int TCK_PERIOD_NS = 160;
  localparam int TCK_HALF_CYC = (TCK_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int IR_W = 4;
  localparam logic [3:0] OP_DEV_RESET = 4'hC;
  localparam logic [3:0] OP_PROG_ENTRY = 4'h4;
  localparam logic [3:0] OP_PROG_CMD = 4'h5;
  localparam logic [3:0] OP_PAGE_LOAD = 4'h6;
  localparam logic [3:0] OP_PAGE_READ = 4'h7;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET_VAL = 4'hF;
  localparam int EN_W = 16;
  localparam logic [15:0] PROG_SIGNATURE = 16'hA370;
  localparam logic [15:0] EN_RESET_VAL = 16'h0000;
  localparam int CMD_W = 15;
  localparam int BYTE_W = 8;
  localparam int PAGE_BITS = 2048;
  localparam int PAGE_BYTES = PAGE_BITS / BYTE_W;
  localparam int ADDR_W = $clog2(PAGE_BYTES);
  localparam int RD_LEAD_BITS = 8;
  localparam int RD_CHAIN_BITS = PAGE_BITS + RD_LEAD_BITS;
  localparam int DIS_CLR_CYC = 2;
  localparam int TOUT_BASE_CYC = 16;
  localparam int TOUT_W = 16;
  localparam int LEN_W = 12;
  localparam logic [5:0] PRE_RESET = 6'h1F;
  localparam logic [5:0] PRE_IR = 6'h03;
  localparam logic [5:0] PRE_DR = 6'h01;
  localparam logic [5:0] PRE_IDLE = 6'h00;
  localparam logic [2:0] PRE_RESET_N = 3'h6;
  localparam logic [2:0] PRE_IR_N = 3'h4;
  localparam logic [2:0] PRE_DR_N = 3'h3;
  localparam logic [2:0] PRE_IDLE_N = 3'h1;
  localparam logic [1:0] POST_SCAN_N = 2'h2;

  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR,
    T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UPD_IR
  } spm_tap_t;

  typedef enum logic [1:0] {HK_RESET, HK_IDLE, HK_IR, HK_DR} spm_kind_t;
endpackage

// ==== test/scan_port_memory_programming_bench.sv ====
/*
 * Self-checking bench: host end drives the device end over the link.
 * Assumes the package constants; TCK_HALF and TOUT_BASE are shortened.
 */
`timescale 1ns/1ns
module scan_port_memory_programming_bench;
  import spm_pkg::*;
  localparam int TB = 4;
  localparam int TH = 8;
  logic clk_in, rst_n_in, fuse_en, dis_set, ext_rst_n, cmd_valid, cmd_ready, take;
  logic rx_valid, done, chip_rst, prog_mode, dis_bit, cmd_apply, cmd_exec, pbuf_wr, rd_req;
  logic [1:0] tout_sel;
  logic [CMD_W-1:0] result, cmd, c;
  logic [7:0] rd_data, pdata, rd_key;
  logic [ADDR_W-1:0] paddr, raddr;
  spm_kind_t kind;
  logic [LEN_W-1:0] len;
  logic [15:0] data, rx_word, v;
  logic [15:0] txq[$];
  logic [15:0] rxq[$];
  logic [7:0] pbuf[PAGE_BYTES];
  int fail_count, n_compared, n_wr, n_exec, n_apply, n_req, t, b, p;

  spm_link_if lnk ();
  spm_dev #(.TOUT_BASE(TB)) u_spm_dev (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(lnk),
    .fuse_en_in(fuse_en), .disable_set_in(dis_set), .ext_rst_n_in(ext_rst_n),
    .tout_sel_in(tout_sel), .result_in(result), .rd_data_in(rd_data),
    .chip_rst_out(chip_rst), .prog_mode_out(prog_mode), .disable_bit_out(dis_bit),
    .cmd_out(cmd), .cmd_apply_out(cmd_apply), .cmd_exec_out(cmd_exec),
    .pbuf_wr_out(pbuf_wr), .pbuf_addr_out(paddr), .pbuf_data_out(pdata),
    .rd_req_out(rd_req), .rd_addr_out(raddr));
  spm_host #(.TCK_HALF(TH)) u_spm_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(lnk),
    .cmd_valid_in(cmd_valid), .cmd_kind_in(kind), .cmd_len_in(len), .cmd_data_in(data),
    .cmd_ready_out(cmd_ready), .word_take_out(take), .rx_word_out(rx_word),
    .rx_valid_out(rx_valid), .done_out(done));
  spm_chk #(.TCK_HALF(TH)) u_spm_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .tck_in(lnk.tck), .tms_in(lnk.tms), .tdi_in(lnk.tdi), .tdo_in(lnk.tdo));

  // The address stands from request on, so a function of it meets the hold time.
  assign rd_data = raddr ^ rd_key;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      n_wr <= 0;
      n_exec <= 0;
      n_apply <= 0;
      n_req <= 0;
    end else begin
      if (pbuf_wr === 1'b1) begin
        pbuf[paddr] <= pdata;
        n_wr <= n_wr + 1;
      end
      if (cmd_exec === 1'b1) begin
        n_exec <= n_exec + 1;
      end
      n_apply <= n_apply + int'(cmd_apply === 1'b1);
      n_req <= n_req + int'(rd_req === 1'b1);
    end
  end

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Page read returns the address mixed with the key that the flash model uses.
  function automatic logic [7:0] exp_rd(input int k);
    return 8'(k) ^ rd_key;
  endfunction

  task automatic tally_and_finish();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask

  // Next word goes up at each take pulse, well before the following tck fall.
  task automatic xfer(input spm_kind_t k, input int n);
    int w;
    int s;
    w = 0;
    s = 0;
    chk({15'h0, cmd_ready}, 16'h0001);
    rxq.delete();
    cmd_valid = 1'b1;
    kind = k;
    len = LEN_W'(n);
    data = txq.size() > 0 ? txq[0] : 16'h0000;
    do begin
      tick();
      s++;
      if (take === 1'b1) begin
        cmd_valid = 1'b0;
        w++;
        data = w < txq.size() ? txq[w] : 16'h0000;
      end
      if (rx_valid === 1'b1) rxq.push_back(rx_word);
    end while (done !== 1'b1 && s < 40000);
    if (s >= 40000) begin
      fail_count++;
      tally_and_finish();
    end
    tick();
  endtask

  task automatic dr(input int n, input logic [15:0] val);
    txq.delete();
    txq.push_back(val);
    xfer(HK_DR, n);
  endtask

  task automatic ir(input logic [3:0] op);
    txq.delete();
    txq.push_back({12'h000, op});
    xfer(HK_IR, IR_W);
  endtask

  initial begin
    rst_n_in = 1'b0;
    fuse_en = 1'b1;
    dis_set = 1'b0;
    ext_rst_n = 1'b1;
    tout_sel = 2'h3;
    result = 15'h0000;
    cmd_valid = 1'b0;
    kind = HK_IDLE;
    len = 12'h000;
    data = 16'h0000;
    rd_key = 8'h00;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(32'hB37E344E));
    repeat (6) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    tick();
    tick();
    xfer(HK_RESET, 1);
    xfer(HK_IDLE, 1);
    dis_set = 1'b1;
    tick();
    dis_set = 1'b0;
    tick();
    chk({15'h0, dis_bit}, 16'h0001);
    ir(OP_PROG_CMD);
    chk(rxq[0], 16'h0000);
    ext_rst_n = 1'b0;
    tick();
    chk({15'h0, dis_bit}, 16'h0001);
    repeat (8) tick();
    chk({15'h0, dis_bit}, 16'h0000);
    chk({15'h0, chip_rst}, 16'h0001);
    ext_rst_n = 1'b1;
    fuse_en = 1'b0;
    ir(OP_PROG_CMD);
    chk(rxq[0], 16'h0000);
    fuse_en = 1'b1;
    xfer(HK_RESET, 1);
    xfer(HK_IDLE, 1);
    ir(OP_DEV_RESET);
    chk(rxq[0], {12'h000, IR_CAPTURE});
    dr(1, 16'h0001);
    chk({15'h0, chip_rst}, 16'h0001);
    dr(1, 16'h0000);
    chk({15'h0, chip_rst}, 16'h0001);
    t = 0;
    while (chip_rst === 1'b1 && t < 600) begin
      tick();
      t++;
    end
    if (t >= 600) begin
      fail_count++;
      tally_and_finish();
    end
    chk({15'h0, chip_rst}, 16'h0000);
    chk({15'h0, t > 150 && t < (TB << 6)}, 16'h0001);
    ir(OP_PROG_ENTRY);
    v = 16'($urandom);
    for (int i = 0; i < 3; i++) begin
      if (i == 1) v = PROG_SIGNATURE ^ 16'h8000;
      if (i == 2) v = PROG_SIGNATURE;
      dr(EN_W, v);
      chk({15'h0, prog_mode}, {15'h0, v == PROG_SIGNATURE});
    end
    ir(OP_PROG_CMD);
    for (int i = 0; i < 4; i++) begin
      result = CMD_W'($urandom);
      c = CMD_W'($urandom);
      t = n_apply;
      dr(CMD_W, {1'b0, c});
      chk(16'(n_apply - t), 16'h0001);
      chk({1'b0, cmd}, {1'b0, c});
      chk(rxq[0], {1'b0, result});
      b = n_exec;
      xfer(HK_IDLE, 1);
      chk(16'(n_exec - b), 16'h0001);
    end
    ir(OP_PAGE_LOAD);
    txq.delete();
    for (int i = 0; i < PAGE_BITS / 16; i++) txq.push_back(16'($urandom));
    b = n_wr;
    xfer(HK_DR, PAGE_BITS);
    chk(16'(n_wr - b), 16'(PAGE_BYTES));
    for (int k = 0; k < PAGE_BYTES; k++) begin
      chk({8'h00, pbuf[k]}, {8'h00, txq[k / 2][8 * (k % 2) +: 8]});
    end
    rd_key = 8'($urandom);
    ir(OP_PAGE_READ);
    txq.delete();
    for (int i = 0; i < 129; i++) txq.push_back(16'($urandom));
    b = n_req;
    xfer(HK_DR, RD_CHAIN_BITS);
    chk(16'(n_req - b), 16'(RD_CHAIN_BITS / BYTE_W));
    chk(16'(rxq.size()), 16'd129);
    for (int k = 0; k < PAGE_BYTES && rxq.size() == 129; k++) begin
      p = RD_LEAD_BITS + 8 * k;
      chk({8'h00, rxq[p / 16][p % 16 +: 8]}, {8'h00, exp_rd(k)});
    end
    ir(OP_PROG_ENTRY);
    dr(EN_W, EN_RESET_VAL);
    chk({15'h0, prog_mode}, 16'h0000);
    tally_and_finish();
  end
endmodule

// ==== test/spm_chk.sv ====
/*
 * Wire-level checker for the scan-port programming link.
 * Assumes it is instantiated beside the link interface, fed by its four pins,
 * and that TCK_HALF matches the value given to the host end.
 */
`timescale 1ns/1ns
module spm_chk #(
  parameter int TCK_HALF = 8
) (
  input logic clk_in,
  input logic rst_n_in,
  input logic tck_in,
  input logic tms_in,
  input logic tdi_in,
  input logic tdo_in
);
  logic [7:0] hi_cnt_ff;

  // Counts clock cycles of the current high phase of tck.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_cnt_ff <= 8'h00;
    end else begin
      hi_cnt_ff <= tck_in ? hi_cnt_ff + 8'h01 : 8'h00;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_fall;
    $fell(tck_in);
  endsequence
  sequence s_lo_run;
    !tck_in[*7];
  endsequence

  property p_tck_high;
    s_fall |-> hi_cnt_ff == 8'(TCK_HALF);
  endproperty
  a_tck_high: assert property (p_tck_high) else $error("tck high phase has wrong length");
  property p_tck_low;
    s_fall |=> s_lo_run;
  endproperty
  a_tck_low: assert property (p_tck_low) else $error("tck low phase too short");
  property p_tms_hold;
    tck_in |-> $stable(tms_in);
  endproperty
  a_tms_hold: assert property (p_tms_hold) else $error("tms moved while tck high");
  property p_tdi_hold;
    tck_in |-> $stable(tdi_in);
  endproperty
  a_tdi_hold: assert property (p_tdi_hold) else $error("tdi moved while tck high");
  property p_tdo_hold;
    tck_in |-> $stable(tdo_in);
  endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved while tck high");
  property p_tdo_settle;
    s_fall |=> $stable(tdo_in)[*2];
  endproperty
  a_tdo_settle: assert property (p_tdo_settle) else $error("tdo moved too soon after fall");
  property p_tdo_window;
    $changed(tdo_in) |-> !tck_in && !$past(tck_in, 3);
  endproperty
  a_tdo_window: assert property (p_tdo_window) else $error("tdo moved outside its window");
  property p_reset_quiet;
    $rose(rst_n_in) |-> !tdo_in && !tck_in && !tms_in && !tdi_in;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins not low after reset");
endmodule
